//--- hdl/scirq_control.v
/*
 Per-channel receive, transmit and status-change interrupt and DMA request
 control of a multiprotocol serial channel.
 Assumes the shifters, buffers and status sources give one-cycle pulses on
 clk, the host gives command pulses on clk, and the modem status lines are
 asynchronous pins.
*/
// What this block does
// (R1) Bit-oriented mode with detection on: frames under 32 bits are short.
// (R2) A short frame sets status bit D3 and a special receive interrupt.
// (R3) Overrun mode 0: overrun shown when offending character reaches last stage.
// (R4) Overrun mode 1: overrun flag and interrupt raised when it happens.
// (R5) First mode with mask: no first-data interrupt, next-character command ignored.
// (R6) The mask never suppresses special receive interrupts.
// (R7) Receive mode 00: no receive data interrupts, host polls.
// (R8) Receive mode 01: interrupt only for first data after receiver enable or command 100.
// (R9) First data per protocol: first char, first non-sync, first frame data.
// (R10) After next-character command, next data may interrupt in first mode.
// (R11) Mode 10: interrupt per load; parity error is a special condition.
// (R12) Mode 11: interrupt per load; parity error raises no special interrupt.
// (R13) First-transmit bit 0: no transmit request at enable; host writes first.
// (R14) First-transmit bit 1: transmit request raised at transmit enable.
// (R15) Transmit enable bit 0: transmit request stays inactive.
// (R16) Transmit enable bit 1: request raised when the buffer empties.
// (R17) Status enable 0: no status interrupt, status bits follow live inputs.
// (R18) Status enable 1: changes latch and interrupt per source enable.
// (R19) Short frame detect bit acts only in bit-oriented mode.
// (R20) Command 010 releases the status-change latch.
// (R21) Command 110 clears receive error bits D3 to D7.
// (R22) Command 111 on channel A clears highest pending cause.
// (R23) Command 100 honoured only in first mode, guarantees next interrupt.
// (R24) Reset clears every interrupt control bit.
`timescale 1ns/10ps
`include "scirq_defs.vh"

module scirq_control #(
   parameter ES_W = 4,
   parameter IS_CHAN_A = 1
) (
   input wire clk,
   input wire rst_n,
   input wire ctl_we,
   input wire [7:0] ctl_wdata,
   input wire cmd_valid,
   input wire [2:0] cmd_code,
   input wire [1:0] proto_mode,
   input wire rx_enable,
   input wire tx_enable,
   input wire rx_bit,
   input wire frame_start,
   input wire frame_end,
   input wire rx_load,
   input wire rx_is_sync,
   input wire addr_search,
   input wire addr_match,
   input wire rx_parity_err,
   input wire rx_overrun,
   input wire tx_empty,
   input wire tx_write,
   input wire [ES_W-1:0] es_pins,
   input wire [ES_W-1:0] es_source_en,
   output reg [7:0] rx_tx_status,
   output reg [ES_W-1:0] special_status,
   output reg rx_irq,
   output reg special_irq,
   output reg tx_request,
   output reg es_irq
);

   reg [7:0] ctl;
   reg [ES_W-1:0] es_meta;
   reg [ES_W-1:0] es_sync;
   reg [ES_W-1:0] es_ref;
   reg es_latched;
   reg [`SCIRQ_FRAME_CNT_W-1:0] frame_bits;
   reg in_frame;
   reg first_pending;
   reg got_sync;
   reg ovr_internal;
   reg tx_armed;
   reg tx_en_d;
   reg rx_en_d;
   reg [2:0] cur_cause;

   wire [1:0] rx_mode;
   wire chan_reset;
   wire is_first;
   wire first_data;
   wire short_det;
   wire parity_sp;
   wire ovr_show;
   wire es_change;
   wire tx_fire;
   wire next_rx_irq;
   wire next_sp;

   assign rx_mode = ctl[`SCIRQ_CTL_RXMODE_HI:`SCIRQ_CTL_RXMODE_LO];
   assign chan_reset = cmd_valid && cmd_code == `SCIRQ_CMD_CHAN_RESET;
   assign is_first = rx_mode == `SCIRQ_RX_FIRST;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt control word.

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl <= `SCIRQ_CTL_RESET; // [R24]
      end else if (chan_reset) begin
         ctl <= `SCIRQ_CTL_RESET; // [R24]
      end else if (ctl_we) begin
         ctl <= ctl_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Short frame counting in every mode; detection in bit-oriented mode only.

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_bits <= {`SCIRQ_FRAME_CNT_W{1'b0}};
         in_frame <= 1'b0;
      end else if (frame_start) begin
         frame_bits <= {`SCIRQ_FRAME_CNT_W{1'b0}};
         in_frame <= 1'b1;
      end else if (frame_end) begin
         in_frame <= 1'b0;
      end else if (in_frame && rx_bit &&
                   frame_bits < `SCIRQ_MIN_FRAME_BITS) begin
         frame_bits <= frame_bits + 1'b1;
      end
   end

   // A frame ending before 32 bits counts as short. [R1] [R19]
   assign short_det = frame_end && in_frame &&
                      ctl[`SCIRQ_CTL_SHORT_FRAME] &&
                      proto_mode == `SCIRQ_PROTO_BIT &&
                      frame_bits < `SCIRQ_MIN_FRAME_BITS;

   ////////////////////////////////////////////////////////////////////////
   // First data tracking.

   // First data differs per protocol. [R9]
   assign first_data = rx_load && first_pending &&
      (proto_mode == `SCIRQ_PROTO_ASYNC ||
       (proto_mode == `SCIRQ_PROTO_CHAR && got_sync && !rx_is_sync) ||
       (proto_mode == `SCIRQ_PROTO_BIT &&
        (!addr_search || addr_match)));

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_pending <= 1'b0;
         got_sync <= 1'b0;
         rx_en_d <= 1'b0;
      end else begin
         rx_en_d <= rx_enable;
         if (chan_reset || !rx_enable) begin
            got_sync <= 1'b0;
         end else if (rx_load && rx_is_sync) begin
            got_sync <= 1'b1;
         end
         if (chan_reset) begin
            first_pending <= 1'b0;
         end else if (rx_enable && !rx_en_d) begin
            first_pending <= 1'b1; // [R8]
         end else if (cmd_valid && cmd_code == `SCIRQ_CMD_NEXT_RX &&
                      is_first && !ctl[`SCIRQ_CTL_FIRST_MASK]) begin
            first_pending <= 1'b1; // [R10] [R23] [R5]
         end else if (first_data) begin
            first_pending <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive status and receive interrupts.

   assign parity_sp = rx_load && rx_parity_err &&
                      rx_mode != `SCIRQ_RX_ALL2; // [R11] [R12]
   // Normal mode shows overrun with the offending load. [R3] [R4]
   assign ovr_show = ctl[`SCIRQ_CTL_OVR_SPECIAL] ? rx_overrun :
                     (rx_load && ovr_internal);
   // Special conditions ignore the first-receive mask. [R6]
   assign next_sp = short_det || parity_sp || ovr_show;

   assign next_rx_irq = rx_load &&
      (rx_mode == `SCIRQ_RX_ALL1 || rx_mode == `SCIRQ_RX_ALL2 ||
       (is_first && first_data && !ctl[`SCIRQ_CTL_FIRST_MASK]));

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovr_internal <= 1'b0;
         rx_tx_status <= 8'h00;
         rx_irq <= 1'b0;
         special_irq <= 1'b0;
      end else if (chan_reset) begin
         ovr_internal <= 1'b0;
         rx_tx_status <= 8'h00;
         rx_irq <= 1'b0;
         special_irq <= 1'b0;
      end else begin
         if (rx_overrun) begin
            ovr_internal <= 1'b1;
         end else if (rx_load) begin
            ovr_internal <= 1'b0;
         end
         if (short_det) begin
            rx_tx_status[`SCIRQ_ST_SHORT] <= 1'b1; // [R2]
         end else if (cmd_valid && cmd_code == `SCIRQ_CMD_ERR_RESET) begin
            rx_tx_status[`SCIRQ_ST_SHORT] <= 1'b0; // [R21]
         end
         if (rx_load && rx_parity_err) begin
            rx_tx_status[`SCIRQ_ST_PARITY] <= 1'b1;
         end else if (cmd_valid && cmd_code == `SCIRQ_CMD_ERR_RESET) begin
            rx_tx_status[`SCIRQ_ST_PARITY] <= 1'b0; // [R21]
         end
         if (ovr_show) begin
            rx_tx_status[`SCIRQ_ST_OVERRUN] <= 1'b1; // [R3] [R4]
         end else if (cmd_valid && cmd_code == `SCIRQ_CMD_ERR_RESET) begin
            rx_tx_status[`SCIRQ_ST_OVERRUN] <= 1'b0; // [R21]
         end
         if (cmd_valid && cmd_code == `SCIRQ_CMD_ERR_RESET) begin
            rx_tx_status[7:6] <= 2'h0; // [R21]
         end
         rx_tx_status[2:0] <= {tx_empty, 1'b0, rx_load};
         // Mode 00 never gets here since next_rx_irq is low. [R7]
         if (next_rx_irq) begin
            rx_irq <= 1'b1;
         end else if (cmd_valid && cmd_code == `SCIRQ_CMD_EOI &&
                      IS_CHAN_A != 0 && cur_cause == 3'h1) begin
            rx_irq <= 1'b0; // [R22]
         end
         if (next_sp) begin
            special_irq <= 1'b1; // [R2] [R6]
         end else if (cmd_valid && (cmd_code == `SCIRQ_CMD_ERR_RESET ||
                      (cmd_code == `SCIRQ_CMD_EOI && IS_CHAN_A != 0 &&
                       cur_cause == 3'h0))) begin
            special_irq <= 1'b0; // [R22]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit request.

   // Enable edge fires only with the first-transmit bit. [R13] [R14]
   assign tx_fire = ctl[`SCIRQ_CTL_TX_EN] &&
      ((tx_enable && !tx_en_d && ctl[`SCIRQ_CTL_FIRST_TX]) ||
       (tx_empty && tx_armed)); // [R15] [R16]

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_en_d <= 1'b0;
         tx_armed <= 1'b0;
         tx_request <= 1'b0;
      end else if (chan_reset) begin
         tx_en_d <= 1'b0;
         tx_armed <= 1'b0;
         tx_request <= 1'b0;
      end else begin
         tx_en_d <= tx_enable;
         // Arming waits for a host write, so the first byte is direct.
         if (!tx_enable) begin
            tx_armed <= 1'b0;
         end else if (tx_write) begin
            tx_armed <= 1'b1; // [R13]
         end else if (tx_empty) begin
            tx_armed <= 1'b0;
         end
         if (tx_fire) begin
            tx_request <= 1'b1;
         end else if (tx_write || !ctl[`SCIRQ_CTL_TX_EN] ||
                      (cmd_valid && (cmd_code == `SCIRQ_CMD_TX_PEND ||
                       (cmd_code == `SCIRQ_CMD_EOI && IS_CHAN_A != 0 &&
                        cur_cause == 3'h2)))) begin
            tx_request <= 1'b0; // [R15] [R22]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // External and status change.

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         es_meta <= {ES_W{1'b0}};
         es_sync <= {ES_W{1'b0}};
      end else begin
         es_meta <= es_pins;
         es_sync <= es_meta;
      end
   end

   assign es_change = |((es_sync ^ es_ref) & es_source_en);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         es_ref <= {ES_W{1'b0}};
         es_latched <= 1'b0;
         special_status <= {ES_W{1'b0}};
         es_irq <= 1'b0;
      end else if (chan_reset) begin
         es_ref <= {ES_W{1'b0}};
         es_latched <= 1'b0;
         special_status <= {ES_W{1'b0}};
         es_irq <= 1'b0;
      end else if (!ctl[`SCIRQ_CTL_ES_EN]) begin
         es_ref <= es_sync;
         es_latched <= 1'b0;
         special_status <= es_sync; // [R17]
         es_irq <= 1'b0; // [R17]
      end else if (!es_latched && es_change) begin
         es_latched <= 1'b1; // [R18]
         special_status <= es_sync;
         es_irq <= 1'b1; // [R18]
      end else if (cmd_valid && cmd_code == `SCIRQ_CMD_RESET_ES) begin
         es_latched <= 1'b0; // [R20]
         es_ref <= special_status;
         es_irq <= 1'b0;
      end else if (!es_latched) begin
         es_ref <= es_sync;
         special_status <= es_sync;
      end else if (cmd_valid && cmd_code == `SCIRQ_CMD_EOI &&
                   IS_CHAN_A != 0 && cur_cause == 3'h3) begin
         es_irq <= 1'b0; // [R22]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Highest pending cause, used by end of interrupt.

   // Decoded from the live flags, so an end of interrupt issued right
   // after a request still clears the cause that is really on top.
   always @* begin
      if (special_irq) begin
         cur_cause = 3'h0;
      end else if (rx_irq) begin
         cur_cause = 3'h1;
      end else if (tx_request) begin
         cur_cause = 3'h2;
      end else if (es_irq) begin
         cur_cause = 3'h3;
      end else begin
         cur_cause = 3'h7;
      end
   end

endmodule

//--- common/scirq_defs.vh
/*
 Constants for the serial channel receive/transmit interrupt control block:
 field positions of the interrupt control word, status bit positions,
 command codes, mode codes and reset values.
 Assumes inclusion by bare name from the design file.
*/
`ifndef SCIRQ_DEFS_VH
`define SCIRQ_DEFS_VH

// Fields of rx_tx_interrupt_control.
`define SCIRQ_CTL_SHORT_FRAME 7
`define SCIRQ_CTL_OVR_SPECIAL 6
`define SCIRQ_CTL_FIRST_MASK 5
`define SCIRQ_CTL_RXMODE_HI 4
`define SCIRQ_CTL_RXMODE_LO 3
`define SCIRQ_CTL_FIRST_TX 2
`define SCIRQ_CTL_TX_EN 1
`define SCIRQ_CTL_ES_EN 0
`define SCIRQ_CTL_RESET 8'h00

// Receive interrupt modes.
`define SCIRQ_RX_NONE 2'h0
`define SCIRQ_RX_FIRST 2'h1
`define SCIRQ_RX_ALL1 2'h2
`define SCIRQ_RX_ALL2 2'h3

// Protocol modes.
`define SCIRQ_PROTO_ASYNC 2'h0
`define SCIRQ_PROTO_CHAR 2'h1
`define SCIRQ_PROTO_BIT 2'h2

// Command codes of the command field.
`define SCIRQ_CMD_RESET_ES 3'h2
`define SCIRQ_CMD_CHAN_RESET 3'h3
`define SCIRQ_CMD_NEXT_RX 3'h4
`define SCIRQ_CMD_TX_PEND 3'h5
`define SCIRQ_CMD_ERR_RESET 3'h6
`define SCIRQ_CMD_EOI 3'h7

// Bits of rx_tx_status held here.
`define SCIRQ_ST_SHORT 3
`define SCIRQ_ST_PARITY 4
`define SCIRQ_ST_OVERRUN 5

// Shortest frame that is not short, in bits.
`define SCIRQ_MIN_FRAME_BITS 32
`define SCIRQ_FRAME_CNT_W 6

`endif

//--- testbench/scirq_control_assertions.sv
/*
 Port checker for scirq_control: interrupt and request timing.
 Assumes the bind below; it keeps a shadow of the control word.
*/
`timescale 1ns/10ps
module scirq_chk (
   input wire clk,
   input wire rst_n,
   input wire ctl_we,
   input wire [7:0] ctl_wdata,
   input wire cmd_valid,
   input wire [2:0] cmd_code,
   input wire [1:0] proto_mode,
   input wire tx_enable,
   input wire rx_load,
   input wire rx_parity_err,
   input wire rx_overrun,
   input wire frame_end,
   input wire [7:0] rx_tx_status,
   input wire rx_irq,
   input wire special_irq,
   input wire tx_request,
   input wire es_irq
);
   reg [7:0] ctl;
   wire [1:0] rxm = ctl[4:3];
   wire txen = ctl[1];
   wire esen = ctl[0];
   wire sfen = ctl[7];
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ctl <= 8'h00;
      else if (cmd_valid && cmd_code == 3'h3)
         ctl <= 8'h00;
      else if (ctl_we)
         ctl <= ctl_wdata;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rx_none; $rose(rx_irq) |-> $past(rxm) != 2'h0; endproperty
   a_rx_none: assert property (p_rx_none)
      else $error("rx irq in poll mode");
   property p_rx_all; rx_load && ctl[4] |=> rx_irq; endproperty
   a_rx_all: assert property (p_rx_all)
      else $error("rx irq missing after load");
   property p_par2;
      rx_load && rx_parity_err && rxm == 2'h3 && !special_irq && !rx_overrun
         && !frame_end |=> !special_irq;
   endproperty
   a_par2: assert property (p_par2)
      else $error("parity raised special irq");
   property p_tx_off; $rose(tx_request) |-> $past(txen); endproperty
   a_tx_off: assert property (p_tx_off)
      else $error("tx request while disabled");
   property p_tx_first; $rose(tx_enable) && ctl[2] && txen |=> tx_request;
   endproperty
   a_tx_first: assert property (p_tx_first)
      else $error("no tx request at enable");
   property p_es_off; $rose(es_irq) |-> $past(esen); endproperty
   a_es_off: assert property (p_es_off)
      else $error("status irq while disabled");
   property p_short;
      $rose(rx_tx_status[3]) |-> special_irq && $past(proto_mode) == 2'h2
         && $past(sfen);
   endproperty
   a_short: assert property (p_short)
      else $error("short frame flag wrong");
   property p_err_rst;
      cmd_valid && cmd_code == 3'h6 && !rx_load && !rx_overrun && !frame_end
         |=> rx_tx_status[7:3] == 5'h00;
   endproperty
   a_err_rst: assert property (p_err_rst)
      else $error("error bits not cleared");
endmodule
bind scirq_control scirq_chk u_chk (.clk(clk), .rst_n(rst_n),
   .ctl_we(ctl_we), .ctl_wdata(ctl_wdata), .cmd_valid(cmd_valid),
   .cmd_code(cmd_code), .proto_mode(proto_mode), .tx_enable(tx_enable),
   .rx_load(rx_load), .rx_parity_err(rx_parity_err),
   .rx_overrun(rx_overrun), .frame_end(frame_end),
   .rx_tx_status(rx_tx_status), .rx_irq(rx_irq),
   .special_irq(special_irq), .tx_request(tx_request), .es_irq(es_irq));

//--- testbench/scirq_host_model.sv
/*
 Host side model: writes a byte when the transmit request is up.
 Assumes the channel clock and reset; svc_wait sets its response delay.
*/
`timescale 1ns/10ps
module scirq_host_model (
   input wire clk,
   input wire rst_n,
   input wire tx_request,
   input wire svc_en,
   input wire host_first,
   input wire [3:0] svc_wait,
   output reg tx_write
);
   reg [3:0] cnt;
   wire due = svc_en && tx_request && !tx_write && cnt == svc_wait;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_write <= 1'b0;
         cnt <= 4'h0;
      end else begin
         tx_write <= host_first || due;
         if (tx_request && !tx_write && !due)
            cnt <= cnt + 4'h1;
         else
            cnt <= 4'h0;
      end
   end
endmodule

//--- testbench/serial_channel_irq_control_tb.sv
/*
 Bench for scirq_control with a host model on the transmit side.
 Assumes the checker is bound in from its own file.
*/
`timescale 1ns/10ps
module serial_channel_irq_control_tb;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg ctl_we, cmd_valid, rx_enable, tx_enable, rx_bit, frame_start;
   reg frame_end, rx_load, rx_parity_err, rx_overrun, tx_empty;
   reg svc_en, host_first;
   reg rx_sync, a_search, a_match;
   reg [3:0] es_en;
   reg [7:0] ctl_wdata;
   reg [2:0] cmd_code;
   reg [1:0] proto_mode;
   reg [3:0] es_pins, svc_wait;
   reg [11:0] r;
   wire tx_write, rx_irq, special_irq, tx_request, es_irq;
   wire [7:0] rx_tx_status;
   wire [3:0] special_status;
   int num_errors = 0;
   int n_checks = 0;
   // Rows: control word, parity, overrun, expected rx irq, special irq.
   localparam logic [11:0] ROWS [0:6] = '{12'h000, 12'h082, 12'h280,
      12'h10B, 12'h18A, 12'h107, 12'h685};
   always #2.5 clk = ~clk;
   scirq_control dut (.clk(clk), .rst_n(rst_n), .ctl_we(ctl_we),
      .ctl_wdata(ctl_wdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .proto_mode(proto_mode), .rx_enable(rx_enable),
      .tx_enable(tx_enable), .rx_bit(rx_bit), .frame_start(frame_start),
      .frame_end(frame_end), .rx_load(rx_load), .rx_is_sync(rx_sync),
      .addr_search(a_search), .addr_match(a_match),
      .rx_parity_err(rx_parity_err), .rx_overrun(rx_overrun),
      .tx_empty(tx_empty), .tx_write(tx_write), .es_pins(es_pins),
      .es_source_en(es_en), .rx_tx_status(rx_tx_status),
      .special_status(special_status), .rx_irq(rx_irq),
      .special_irq(special_irq), .tx_request(tx_request), .es_irq(es_irq));
   scirq_host_model host (.clk(clk), .rst_n(rst_n), .tx_request(tx_request),
      .svc_en(svc_en), .host_first(host_first), .svc_wait(svc_wait),
      .tx_write(tx_write));
   task tick();
      @(posedge clk);
      #1;
   endtask
   task chk(input string what, input logic [7:0] seen, input logic [7:0] ex);
      n_checks++;
      if (seen !== ex) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, ex, seen);
      end
   endtask
   task cmd(input logic [2:0] c);
      cmd_valid = 1'b1;
      cmd_code = c;
      tick();
      cmd_valid = 1'b0;
   endtask
   task wctl(input logic [7:0] v);
      ctl_we = 1'b1;
      ctl_wdata = v;
      tick();
      ctl_we = 1'b0;
   endtask
   task load(input logic par);
      rx_parity_err = par;
      rx_load = 1'b1;
      tick();
      rx_load = 1'b0;
   endtask
   task arm(input logic [7:0] v);
      cmd(3'h3);
      rx_enable = 1'b0;
      wctl(v);
      rx_enable = 1'b1;
      tick();
   endtask
   task empty();
      tx_empty = 1'b1;
      tick();
      tx_empty = 1'b0;
   endtask
   task frame(input int n);
      frame_start = 1'b1;
      tick();
      frame_start = 1'b0;
      rx_bit = 1'b1;
      repeat (n) tick();
      rx_bit = 1'b0;
      frame_end = 1'b1;
      tick();
      frame_end = 1'b0;
   endtask
   task report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task wait_drop();
      for (int k = 0; k < 20 && tx_request !== 1'b0; k++) tick();
      chk("tx_request_drop", tx_request, 8'h00);
      if (tx_request !== 1'b0) report_and_stop();
   endtask
   initial begin
      {ctl_we, cmd_valid, rx_enable, tx_enable, rx_bit, frame_start} = 6'h00;
      {frame_end, rx_load, rx_parity_err, rx_overrun, tx_empty} = 5'h00;
      {svc_en, host_first, ctl_wdata, cmd_code, proto_mode} = 15'h0000;
      es_pins = 4'h0;
      svc_wait = 4'h0;
      {rx_sync, a_search, a_match} = 3'h0;
      es_en = 4'hF;
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      chk("irqs", {rx_irq, special_irq, tx_request, es_irq}, 8'h00);
      chk("status", rx_tx_status, 8'h00);
      for (int i = 0; i < 7; i++) begin
         r = ROWS[i];
         cmd(3'h3);
         rx_enable = 1'b0;
         wctl(r[11:4]);
         rx_enable = 1'b1;
         tick();
         rx_overrun = r[2];
         tick();
         rx_overrun = 1'b0;
         chk("sp_early", special_irq, r[2] & r[10]);
         load(r[3]);
         chk("rx_irq", rx_irq, r[1]);
         chk("sp_irq", special_irq, r[0]);
         chk("overrun", rx_tx_status[5], r[2]);
      end
      $display("rows done");
      cmd(3'h3);
      rx_enable = 1'b0;
      wctl(8'h08);
      rx_enable = 1'b1;
      tick();
      load(1'b0);
      chk("first_rx", rx_irq, 8'h01);
      cmd(3'h7);
      chk("eoi", rx_irq, 8'h00);
      load(1'b0);
      chk("second_rx", rx_irq, 8'h00);
      cmd(3'h4);
      load(1'b0);
      chk("next_rx", rx_irq, 8'h01);
      cmd(3'h7);
      wctl(8'h28);
      cmd(3'h4);
      wctl(8'h08);
      load(1'b0);
      chk("masked_next", rx_irq, 8'h00);
      proto_mode = 2'h1;
      arm(8'h08);
      load(1'b0);
      chk("pre_sync", rx_irq, 8'h00);
      rx_sync = 1'b1;
      load(1'b0);
      rx_sync = 1'b0;
      chk("sync_char", rx_irq, 8'h00);
      load(1'b0);
      chk("first_char", rx_irq, 8'h01);
      proto_mode = 2'h2;
      a_search = 1'b1;
      arm(8'h08);
      load(1'b0);
      chk("addr_miss", rx_irq, 8'h00);
      a_match = 1'b1;
      load(1'b0);
      chk("addr_hit", rx_irq, 8'h01);
      {proto_mode, a_search, a_match} = 4'h0;
      $display("first mode done");
      cmd(3'h3);
      proto_mode = 2'h2;
      wctl(8'h80);
      frame(31);
      chk("short", rx_tx_status[3], 8'h01);
      chk("short_sp", special_irq, 8'h01);
      cmd(3'h6);
      chk("err_bits", rx_tx_status & 8'hF8, 8'h00);
      chk("err_sp", special_irq, 8'h00);
      frame(32);
      chk("long", rx_tx_status[3], 8'h00);
      proto_mode = 2'h0;
      frame(31);
      chk("async_short", rx_tx_status[3], 8'h00);
      $display("short frame done");
      cmd(3'h3);
      svc_en = 1'b1;
      wctl(8'h06);
      tx_enable = 1'b1;
      tick();
      chk("first_tx", tx_request, 8'h01);
      wait_drop();
      empty();
      chk("tx_empty", tx_request, 8'h01);
      wait_drop();
      svc_wait = 4'h3;
      tx_enable = 1'b0;
      wctl(8'h02);
      tx_enable = 1'b1;
      tick();
      chk("no_first_tx", tx_request, 8'h00);
      host_first = 1'b1;
      tick();
      host_first = 1'b0;
      tick();
      empty();
      chk("tx_after_host", tx_request, 8'h01);
      wait_drop();
      wctl(8'h04);
      empty();
      chk("tx_off", tx_request, 8'h00);
      svc_en = 1'b0;
      tx_enable = 1'b0;
      wctl(8'h06);
      tx_enable = 1'b1;
      tick();
      chk("tx_first2", tx_request, 8'h01);
      cmd(3'h7);
      chk("tx_eoi", tx_request, 8'h00);
      $display("transmit done");
      cmd(3'h3);
      wctl(8'h01);
      es_pins = 4'h1;
      repeat (4) tick();
      chk("es_irq", es_irq, 8'h01);
      chk("es_latch", special_status[0], 8'h01);
      cmd(3'h2);
      chk("es_release", es_irq, 8'h00);
      wctl(8'h00);
      es_pins = 4'h0;
      repeat (4) tick();
      chk("es_off", es_irq, 8'h00);
      chk("es_live", special_status[0], 8'h00);
      es_en = 4'hE;
      wctl(8'h01);
      es_pins = 4'h1;
      repeat (4) tick();
      chk("es_masked", es_irq, 8'h00);
      $display("status change done");
      report_and_stop();
   end
endmodule
